// ---- hdl/frame_average_and_luma_lut.v ----
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "frame_post_map.vh"

module frame_average_and_luma_lut #(
  parameter PIXELS   = 16,
  parameter PIX_AW   = 4,
  parameter CHUNK_W  = 32
) (
  input  wire               mclk,
  input  wire               rst_b,
  input  wire [3:0]         reg_addr,
  input  wire [15:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [15:0]        reg_rdata,
  input  wire               frame_trigger,
  input  wire               single_frame_mode,
  input  wire               pix_valid,
  input  wire [11:0]        pix_data,
  input  wire               pix_last,
  input  wire [CHUNK_W-1:0] chunk_in,
  output reg                out_valid,
  output reg  [11:0]        out_data,
  output reg                out_last,
  output reg  [CHUNK_W-1:0] chunk_out,
  output reg                exposure_end_event,
  output reg                acq_done
);

  // ----------------------------------------
  // settings
  // ----------------------------------------
  reg [8:0]  frame_average_count;
  reg        seq_on;
  reg        table_select;
  reg [11:0] table_entry_index;
  reg        table_apply_on;
  reg        fmt_8bit;
  reg        chunk_on;
  reg        event_on;
  reg [11:0] luma_table [0:511];

  // ----------------------------------------
  // averaging state
  // ----------------------------------------
  // wide accumulators
  reg [19:0] accum [0:PIXELS-1];
  reg [PIX_AW-1:0] pix_pos_reg;
  reg [8:0]  frames_done_reg;
  reg        in_frame_reg;
  reg        single_done_reg;
  reg [CHUNK_W-1:0] chunk_hold;

  wire avg_active = (frame_average_count > 9'h001) && !seq_on;
  wire frame_start = frame_trigger && !in_frame_reg && !single_done_reg;

  // the quotient fits 12 bits while the sum holds at most cnt values; a count lowered mid-set can break this, and the top bits are cut
  function [11:0] div_trunc;
    input [19:0] sum;
    input [8:0]  cnt;
    reg   [19:0] quot;
    begin
      quot = 20'h0_0000;
      if (cnt != 9'h000)
        quot = sum / {11'h000, cnt};
      div_trunc = quot[11:0];
    end
  endfunction

  function [11:0] lerp;
    input [11:0] lo;
    input [11:0] hi;
    input [2:0]  frac;
    reg signed [14:0] diff;
    reg signed [18:0] step;
    begin
      diff = $signed({3'b000, hi}) - $signed({3'b000, lo});
      step = diff * $signed({1'b0, frac});
      lerp = lo + step[14:3];
      if (step < 0 && step[2:0] != 3'b000)
        lerp = lo + step[14:3] + 12'h001;
    end
  endfunction

  // ----------------------------------------
  // register port
  // ----------------------------------------
  // a zero count would leave the divider without a divisor, and a count
  // beyond the largest set would overflow the accumulators: clamp both,
  // judging the whole written word so that high bits are not lost
  function [8:0] count_clamp;
    input [15:0] wval;
    begin
      if (wval == 16'h0000)
        count_clamp = 9'h001;
      else if (wval > {7'h00, `AVG_COUNT_MAX})
        count_clamp = `AVG_COUNT_MAX;
      else
        count_clamp = wval[8:0];
    end
  endfunction

  wire       wr_table_value = reg_wr && (reg_addr == `REG_TABLE_VALUE);
  wire       index_on_step  = (table_entry_index[`TABLE_STEP_BITS-1:0] == 3'b000);
  wire [8:0] entry_slot     = table_entry_index[11:3];

  always @(posedge mclk) begin
    if (!rst_b) begin
      frame_average_count <= `AVG_COUNT_RESET;
      seq_on <= 1'b0;
      table_select <= `LUMA_TABLE_CODE;
      table_entry_index <= 12'h000;
      table_apply_on <= 1'b0;
      fmt_8bit <= 1'b0;
      chunk_on <= 1'b0;
      event_on <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_AVG_COUNT: begin
          frame_average_count <= count_clamp(reg_wdata);
        end

        `REG_SEQ_ON: begin
          seq_on <= reg_wdata[0];
        end

        `REG_TABLE_SEL: begin
          table_select <= `LUMA_TABLE_CODE;
        end

        `REG_TABLE_INDEX: begin
          table_entry_index <= reg_wdata[11:0];
        end

        `REG_TABLE_ON: begin
          table_apply_on <= reg_wdata[0];
        end

        `REG_FMT_8BIT: begin
          fmt_8bit <= reg_wdata[0];
        end

        `REG_CHUNK_ON: begin
          chunk_on <= reg_wdata[0];
        end

        `REG_EVENT_ON: begin
          event_on <= reg_wdata[0];
        end

        default: begin
        end
      endcase
    end
  end

  // value stored at index; only multiples of 8 kept
  // off-step indices are dropped here, so unused slots need no storage
  always @(posedge mclk) begin
    if (wr_table_value && index_on_step)
      luma_table[entry_slot] <= reg_wdata[11:0];
  end

  reg [15:0] rdata_next;

  // data stand only in the cycle after the strobe and are zero otherwise,
  // so several read ports can share one or-ed bus
  always @* begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_AVG_COUNT: begin
          rdata_next = {7'h00, frame_average_count};
        end

        `REG_SEQ_ON: begin
          rdata_next = {15'h0000, seq_on};
        end

        `REG_TABLE_SEL: begin
          rdata_next = {15'h0000, table_select};
        end

        `REG_TABLE_INDEX: begin
          rdata_next = {4'h0, table_entry_index};
        end

        `REG_TABLE_VALUE: begin
          rdata_next = {4'h0, luma_table[entry_slot]};
        end

        `REG_TABLE_ON: begin
          rdata_next = {15'h0000, table_apply_on};
        end

        `REG_FMT_8BIT: begin
          rdata_next = {15'h0000, fmt_8bit};
        end

        `REG_CHUNK_ON: begin
          rdata_next = {15'h0000, chunk_on};
        end

        `REG_EVENT_ON: begin
          rdata_next = {15'h0000, event_on};
        end

        `REG_STATUS: begin
          rdata_next = {4'h0, single_done_reg, in_frame_reg, avg_active, frames_done_reg};
        end

        default: begin
          rdata_next = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rdata_next;
  end

  // ----------------------------------------
  // averager
  // ----------------------------------------
  // pixels outside an opened frame are ignored, which also keeps a finished
  // single-frame run from touching the accumulators
  wire        take = pix_valid && in_frame_reg;
  wire [19:0] acc_now = accum[pix_pos_reg];

  // the first frame of a set overwrites instead of adding, so the
  // accumulators never need a clearing pass between sets
  wire        first_frame = (frames_done_reg == 9'h000);
  wire [19:0] acc_sum = (first_frame ? 20'h0_0000 : acc_now) + {8'h00, pix_data};

  // a count lowered mid-set ends the set at once rather than running on
  wire        set_last = (frames_done_reg + 9'h001 >= frame_average_count);
  reg         avg_valid;
  reg  [11:0] avg_data;
  reg         avg_last;

  always @(posedge mclk) begin
    if (!rst_b) begin
      pix_pos_reg <= {PIX_AW{1'b0}};
      frames_done_reg <= 9'h000;
      in_frame_reg <= 1'b0;
      single_done_reg <= 1'b0;
      avg_valid <= 1'b0;
      avg_data <= 12'h000;
      avg_last <= 1'b0;
      chunk_out <= {CHUNK_W{1'b0}};
      chunk_hold <= {CHUNK_W{1'b0}};
      exposure_end_event <= 1'b0;
      acq_done <= 1'b0;
    end else begin
      avg_valid <= 1'b0;
      avg_last <= 1'b0;
      exposure_end_event <= 1'b0;
      acq_done <= 1'b0;

      // leaving single-frame mode rearms the trigger
      if (!single_frame_mode) begin
        single_done_reg <= 1'b0;
      end

      // one trigger opens each individual frame
      if (frame_start) begin
        in_frame_reg <= 1'b1;
        pix_pos_reg <= {PIX_AW{1'b0}};
      end

      if (take) begin
        pix_pos_reg <= pix_pos_reg + {{(PIX_AW-1){1'b0}}, 1'b1};

        if (!avg_active) begin
          avg_valid <= 1'b1;
          avg_data <= pix_data;
          avg_last <= pix_last;
        end else begin
          accum[pix_pos_reg] <= acc_sum;

          // truncated mean on the last frame
          if (set_last) begin
            avg_valid <= 1'b1;
            avg_data <= div_trunc(acc_sum, frame_average_count);
            avg_last <= pix_last;
          end
        end

        if (pix_last) begin
          in_frame_reg <= 1'b0;
          exposure_end_event <= event_on;
          chunk_hold <= chunk_on ? chunk_in : {CHUNK_W{1'b0}};
          if (!avg_active || set_last) begin
            frames_done_reg <= 9'h000;
            chunk_out <= chunk_on ? chunk_in : {CHUNK_W{1'b0}};
            acq_done <= 1'b1;
            // single mode stops after one output frame
            if (single_frame_mode)
              single_done_reg <= 1'b1;
          end else
            frames_done_reg <= frames_done_reg + 9'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // lookup stage
  // ----------------------------------------
  // the table is read without a clock so the mapping adds only the one
  // output register; the price is two read ports on the table array
  wire [8:0]  lo_idx = avg_data[11:3];

  // wraps at the last slot, where the clamp below takes over
  wire [8:0]  hi_idx = lo_idx + 9'h001;
  wire [11:0] lo_val = luma_table[lo_idx];
  wire [11:0] hi_val = luma_table[hi_idx];
  reg  [11:0] mapped;

  always @* begin
    mapped = avg_data;

    if (table_apply_on) begin
      if (avg_data >= `TABLE_LAST_USED) begin
        mapped = luma_table[9'h1ff];
      end else begin
        mapped = lerp(lo_val, hi_val, avg_data[2:0]);
      end
    end
  end

  // ----------------------------------------
  // output register
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= 12'h000;
      out_last <= 1'b0;
    end else begin
      out_valid <= avg_valid;
      out_last <= avg_last;

      if (fmt_8bit) begin
        out_data <= {4'h0, mapped[11:`FMT8_DROP_BITS]};
      end else begin
        out_data <= mapped;
      end
    end
  end

endmodule

// ---- hdl/frame_post_map.vh ----
// Operation
// - averager combines 2 to 256 consecutive triggered frames into one output frame
// - per pixel sum over set, divide by count, truncate fraction
// - each frame of a set needs its own trigger; count triggers equal frame count
// - single-frame mode yields exactly one averaged frame from the set
// - averaging works in single/continuous, free-run or triggered acquisition
// - sequencer enabled means averager inactive, frames pass unaveraged
// - setting writes take effect at once, even mid-set
// - one exposure-end event per individual frame, none for averaged frame
// - averaged frame carries chunk data of the last individual frame
// - one output frame per completed set
// - frame count 1 disables averaging; larger enables it
// - enabled table maps 12-bit codes to 12-bit via 4096 entries
// - 12-bit formats carry table output if enabled, else ADC value
// - only entries at multiples of 8 are used; exact hits output entry
// - between used entries, output is straight-line interpolation
// - inputs above 4088 output entry 4088; entries 4089-4095 ignored
// - 8-bit formats take table result and drop lowest 4 bits
// - software selects table, sets index, writes value, then enables
// - selector offers only the luminance table
`ifndef FRAME_POST_MAP_VH
`define FRAME_POST_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_AVG_COUNT   4'h0
`define REG_SEQ_ON      4'h1
`define REG_TABLE_SEL   4'h2
`define REG_TABLE_INDEX 4'h3
`define REG_TABLE_VALUE 4'h4
`define REG_TABLE_ON    4'h5
`define REG_FMT_8BIT    4'h6
`define REG_CHUNK_ON    4'h7
`define REG_EVENT_ON    4'h8
`define REG_STATUS      4'h9

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define AVG_COUNT_RESET 9'h001
`define AVG_COUNT_MAX   9'h100
`define LUMA_TABLE_CODE 1'b0
`define TABLE_LAST_USED 12'hff8
`define TABLE_STEP_BITS 3
`define FMT8_DROP_BITS  4

`endif

// ---- verification/frame_post_chk.sv ----
`timescale 1ns/10ps
module frame_post_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        pix_valid,
  input wire logic        pix_last,
  input wire logic        out_valid,
  input wire logic        out_last,
  input wire logic        exposure_end_event,
  input wire logic        acq_done
);
  // ----
  // port relations
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_rdata_read_slot: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside its slot");
  a_event_frame_end: assert property (exposure_end_event |-> $past(pix_valid && pix_last))
    else $error("event not after frame end");
  a_event_one_pulse: assert property (exposure_end_event |=> !exposure_end_event)
    else $error("event longer than one cycle");
  a_done_frame_end: assert property (acq_done |-> $past(pix_valid && pix_last))
    else $error("done not after frame end");
  a_done_one_pulse: assert property (acq_done |=> !acq_done)
    else $error("done longer than one cycle");
  a_done_out_last: assert property (acq_done |=> out_last)
    else $error("set end without last output");
  a_last_out_cause: assert property (out_last |-> out_valid && $past(pix_valid && pix_last, 2))
    else $error("last output out of place");
  a_out_pixel_cause: assert property (out_valid |-> $past(pix_valid, 2))
    else $error("output without pixel");
endmodule
bind frame_average_and_luma_lut frame_post_chk chk (.mclk(mclk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_last(pix_last), .out_valid(out_valid),
  .out_last(out_last), .exposure_end_event(exposure_end_event), .acq_done(acq_done));

// ---- verification/sensor_model.sv ----
`timescale 1ns/10ps
module sensor_model (
  input  wire        mclk,
  output reg         frame_trigger = 1'b0,
  output reg         pix_valid = 1'b0,
  output reg         pix_last = 1'b0,
  output reg  [11:0] pix_data = 12'h000,
  output reg  [31:0] chunk_in = 32'h0000_0000
);
  // ----
  // frame source
  // ----
  // one trigger per frame
  task automatic run(input logic [191:0] px, input logic slow, input logic [31:0] ck);
    int k;
    frame_trigger <= 1'b1;
    chunk_in      <= ck;
    @(posedge mclk);
    frame_trigger <= 1'b0;
    for (k = 0; k < 16; k++) begin
      pix_valid <= 1'b1;
      pix_data  <= px[k*12 +: 12];
      pix_last  <= (k == 15);
      @(posedge mclk);
      if (slow || k == 15) begin
        // released line shows the inverse, never a stale value
        pix_valid <= 1'b0;
        pix_last  <= 1'b0;
        pix_data  <= ~px[k*12 +: 12];
        @(posedge mclk);
      end
    end
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ---- verification/tb_frame_average_and_luma_lut.sv ----
`timescale 1ns/10ps
module tb_frame_average_and_luma_lut;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        single_frame_mode = 1'b0;
  logic [15:0] reg_rdata;
  logic        frame_trigger, pix_valid, pix_last, out_valid, out_last, exposure_end_event, acq_done;
  logic [11:0] pix_data, out_data;
  logic [31:0] chunk_in, chunk_out, last_ck;
  logic [31:0] seed = 32'h4d49_243c;
  logic [31:0] rq[$], oq[$];
  int          err_total = 0;
  int          samples_checked = 0;
  int          i;
  always #5 mclk = ~mclk;
  sensor_model sen (.mclk(mclk), .frame_trigger(frame_trigger), .pix_valid(pix_valid), .pix_last(pix_last),
    .pix_data(pix_data), .chunk_in(chunk_in));
  frame_average_and_luma_lut #(.PIXELS(16)) uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_trigger(frame_trigger), .single_frame_mode(single_frame_mode), .pix_valid(pix_valid),
    .pix_data(pix_data), .pix_last(pix_last), .chunk_in(chunk_in), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .chunk_out(chunk_out),
    .exposure_end_event(exposure_end_event), .acq_done(acq_done));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // inverted table: entry at n holds 4095 - n
  function automatic logic [11:0] mapv(input logic [19:0] x, input int mode);
    logic [11:0] y;
    y = mode == 0 ? x[11:0] : (x > 4088 ? 12'h007 : 12'hfff - x[11:0]);
    return mode == 2 ? {4'h0, y[11:4]} : y;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(e);
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
  endtask
  // last pixel of each frame is forced into the clamp range of 4088 and above
  task automatic frames(input int n, input int cnt, input int mode, input logic slow, input int outs);
    logic [191:0] px;
    logic [19:0]  sum [16];
    int           f;
    int           k;
    for (f = 0; f < n; f++) begin
      for (k = 0; k < 16; k++) begin
        seed = xs(seed);
        px[k*12 +: 12] = seed[11:0] | (k == 15 ? 12'hff8 : 12'h000);
        sum[k] = (f % cnt == 0 ? 20'h0_0000 : sum[k]) + px[k*12 +: 12];
        if (f % cnt == cnt - 1 && f / cnt < outs) oq.push_back(mapv(sum[k] / cnt, mode));
      end
      last_ck = seed;
      sen.run(px, slow, seed);
    end
  endtask
  // ----
  // monitor and sequence
  // ----
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (rd_d) check(reg_rdata, rq.pop_front());
    if (out_valid) check(out_data, oq.size() ? oq.pop_front() : 32'hxxxx_xxxx);
  end
  initial begin
    #400_000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(4'h0, 16'h0001);
    rd(4'h2, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(4'h7, 16'h0001);
    wr(4'h8, 16'h0001);
    frames(2, 1, 0, 1'b0, 9);
    wr(4'h0, 16'h0003);
    frames(6, 3, 0, 1'b1, 9);
    check(chunk_out, last_ck);
    wr(4'h0, 16'h0200);
    rd(4'h0, 16'h0100);
    wr(4'h1, 16'h0001);
    frames(2, 1, 0, 1'b0, 9);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0002);
    single_frame_mode <= 1'b1;
    frames(4, 2, 0, 1'b0, 1);
    single_frame_mode <= 1'b0;
    wr(4'h0, 16'h0001);
    for (i = 0; i < 4096; i += 8) begin
      wr(4'h3, i[15:0]);
      wr(4'h4, 16'h0fff - i[15:0]);
    end
    wr(4'h3, 16'h0009);
    wr(4'h4, 16'h0abc);
    rd(4'h4, 16'h0ff7);
    wr(4'h5, 16'h0001);
    frames(3, 1, 1, 1'b1, 9);
    wr(4'h6, 16'h0001);
    frames(2, 1, 2, 1'b0, 9);
    repeat (8) @(posedge mclk);
    check(oq.size(), 0);
    close_out();
  end
endmodule
